// >>> logic/mic_irq_controller.v
// Interrupt controller: flags, enables, priority, vectoring, wake-up and AXI4-Lite registers
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`include "mic_irq_consts.vh"

// What this block does
// RULE1 - Edge field: off, rise, fall, both edges
// RULE2 - Flags set always; jump needs enable
// RULE3 - Global enable low blocks every jump
// RULE4 - Take: push PC, load vector
// RULE5 - Return pops saved PC to resume
// RULE6 - Servicing clears global enable automatically
// RULE7 - Blocked requests still latch their flags
// RULE8 - Full stack holds off acknowledgement
// RULE9 - Any newly set flag wakes device
// RULE10 - Software presets flag to avoid wake
// RULE11 - Pin edge of chosen type sets flag
// RULE12 - Pin vector needs global, enable, room
// RULE13 - Servicing pin clears its flag, global
// RULE14 - Software configures pin sharing and direction; this block has only the edge select, with no pin sharing or direction control
// RULE15 - Individual vectors plus two shared requests
// RULE16 - Control register 0 bit layout
// RULE17 - Control register 1 bit layout
// RULE18 - Touch register bit layout
// RULE19 - Timer register bit layout
// RULE20 - Unused bits zero; reset clears all but state, which loads ST_IDLE
// RULE21 - Shared vector clears only shared flag
// RULE22 - Fixed priority, shared as one source
// RULE23 - Distinct fixed vector per request
module mic_irq_controller
(
   // Clock and reset
   input  wire                   clock,
   input  wire                   rst_n,
   // AXI4-Lite write address
   input  wire [11:0]            s_axi_awaddr,
   input  wire                   s_axi_awvalid,
   output wire                   s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0]            s_axi_wdata,
   input  wire [3:0]             s_axi_wstrb,
   input  wire                   s_axi_wvalid,
   output wire                   s_axi_wready,
   // AXI4-Lite write response
   output reg  [1:0]             s_axi_bresp,
   output reg                    s_axi_bvalid,
   input  wire                   s_axi_bready,
   // AXI4-Lite read address
   input  wire [11:0]            s_axi_araddr,
   input  wire                   s_axi_arvalid,
   output wire                   s_axi_arready,
   // AXI4-Lite read data
   output reg  [31:0]            s_axi_rdata,
   output reg  [1:0]             s_axi_rresp,
   output reg                    s_axi_rvalid,
   input  wire                   s_axi_rready,
   // External request pin
   input  wire                   extPin,
   // Peripheral event pulses
   input  wire                   serialIfEvent,
   input  wire                   timebaseEvent,
   input  wire                   eepromDoneEvent,
   input  wire                   touchSlotOvfEvent,
   input  wire                   touchThresholdEvent,
   input  wire                   timerCmpPEvent,
   input  wire                   timerCmpAEvent,
   // Core interface
   input  wire                   coreReady,
   input  wire [`MIC_PC_W-1:0]   corePc,
   input  wire                   stackFull,
   input  wire                   returnFromIrq,
   input  wire [`MIC_PC_W-1:0]   stackTopPc,
   input  wire                   lowPower,
   output reg                    irqTake,
   output reg                    stackPush,
   output reg  [`MIC_PC_W-1:0]   pushPc,
   output reg                    pcLoad,
   output reg  [`MIC_PC_W-1:0]   pcLoadValue,
   output reg                    stackPop,
   output reg                    wakeUp
);

   // Take sequence states
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_PUSH = 3'b010;
   localparam [2:0] ST_LOAD = 3'b100;

   reg  [1:0]            edgeSelReg;
   reg  [7:0]            ctrl0Reg;
   reg  [7:0]            ctrl1Reg;
   reg  [7:0]            touchReg;
   reg  [7:0]            timerReg;
   reg  [2:0]            stateReg;
   reg  [2:0]            stateNext;
   reg  [`MIC_NSRC-1:0]  takenSrcReg;
   reg  [`MIC_PC_W-1:0]  vectorReg;
   reg  [`MIC_PC_W-1:0]  savedPcReg;
   reg                   pinPrevReg;
   reg  [11:0]           awAddrReg;
   reg                   awHeldReg;
   reg  [31:0]           wDataReg;
   reg  [3:0]            wStrbReg;
   reg                   wHeldReg;
   wire                  pinLevel;
   wire                  pinRise;
   wire                  pinFall;
   reg                   extEdge;
   wire [`MIC_NSRC-1:0]  pending;
   reg  [`MIC_NSRC-1:0]  grant;
   reg  [`MIC_PC_W-1:0]  grantVec;
   wire                  canTake;
   wire                  doWrite;
   wire [7:0]            wrByte;
   wire                  doRead;
   reg  [7:0]            rdByte;
   reg                   rdHit;
   wire                  wrHit;
   wire [7:0]            setC0;
   wire [7:0]            setC1;
   wire [7:0]            setTouch;
   wire [7:0]            setTimer;
   wire [7:0]            clrC0;
   wire [7:0]            clrC1;

   // Register update: software write, then hardware clears, then hardware sets win
   function [7:0] upd;
      input [7:0] cur;
      input       we;
      input [7:0] wv;
      input [7:0] mask;
      input [7:0] clr;
      input [7:0] set;
      reg   [7:0] tmp;
      begin
         tmp = we ? (wv & mask) : cur;
         upd = (tmp & ~clr) | set;
      end
   endfunction

   function isAddr;
      input [11:0] addr;
      input [11:0] ofs;
      begin
         isAddr = (addr[11:2] == ofs[11:2]);
      end
   endfunction

   mic_pin_sync uPinSync
   (
      .clock    (clock),
      .rst_n    (rst_n),
      .pinIn    (extPin),
      .levelOut (pinLevel)
   );

   assign pinRise = pinLevel & ~pinPrevReg;
   assign pinFall = ~pinLevel & pinPrevReg;

   // RULE1 edge decode
   always @*
   begin
      case (edgeSelReg)
         `MIC_EDGE_OFF:  extEdge = 1'b0;
         `MIC_EDGE_RISE: extEdge = pinRise;
         `MIC_EDGE_FALL: extEdge = pinFall;
         `MIC_EDGE_BOTH: extEdge = pinRise | pinFall;
         default:        extEdge = 1'b0;
      endcase
   end

   // RULE2 RULE7 RULE11 flags latch unconditionally
   assign setTouch = ({7'b0, touchSlotOvfEvent} << `MIC_B_LO_F)
                   | ({7'b0, touchThresholdEvent} << `MIC_B_HI_F);
   assign setTimer = ({7'b0, timerCmpPEvent} << `MIC_B_LO_F)
                   | ({7'b0, timerCmpAEvent} << `MIC_B_HI_F);
   assign setC1 = ({7'b0, serialIfEvent} << `MIC_B_SERF)
                | ({7'b0, timebaseEvent} << `MIC_B_TBF)
                | ({7'b0, eepromDoneEvent} << `MIC_B_EEF);
   // RULE15 shared flag raised by any included source request
   // Only an enabled source raises its shared flag, so a masked source never vectors
   assign setC0 = ({7'b0, extEdge} << `MIC_B_EXTF)
                | ({7'b0, |(setTouch & (touchReg << `MIC_B_LO_F))} << `MIC_B_SH0F)
                | ({7'b0, |(setTimer & (timerReg << `MIC_B_LO_F))} << `MIC_B_SH1F);

   assign pending[`MIC_SRC_EXT] = ctrl0Reg[`MIC_B_EXTE] & ctrl0Reg[`MIC_B_EXTF];
   assign pending[`MIC_SRC_SER] = ctrl1Reg[`MIC_B_SERE] & ctrl1Reg[`MIC_B_SERF];
   assign pending[`MIC_SRC_TB]  = ctrl1Reg[`MIC_B_TBE] & ctrl1Reg[`MIC_B_TBF];
   assign pending[`MIC_SRC_EE]  = ctrl1Reg[`MIC_B_EEE] & ctrl1Reg[`MIC_B_EEF];
   assign pending[`MIC_SRC_SH0] = ctrl0Reg[`MIC_B_SH0E] & ctrl0Reg[`MIC_B_SH0F];
   assign pending[`MIC_SRC_SH1] = ctrl0Reg[`MIC_B_SH1E] & ctrl0Reg[`MIC_B_SH1F];

   // RULE22 RULE23 fixed priority, one vector each
   always @*
   begin
      grant = {`MIC_NSRC{1'b0}};
      grantVec = `MIC_VEC_EXT;
      if (pending[`MIC_SRC_EXT])
      begin
         grant[`MIC_SRC_EXT] = 1'b1;
         grantVec = `MIC_VEC_EXT;
      end
      else if (pending[`MIC_SRC_SER])
      begin
         grant[`MIC_SRC_SER] = 1'b1;
         grantVec = `MIC_VEC_SER;
      end
      else if (pending[`MIC_SRC_TB])
      begin
         grant[`MIC_SRC_TB] = 1'b1;
         grantVec = `MIC_VEC_TB;
      end
      else if (pending[`MIC_SRC_EE])
      begin
         grant[`MIC_SRC_EE] = 1'b1;
         grantVec = `MIC_VEC_EE;
      end
      else if (pending[`MIC_SRC_SH0])
      begin
         grant[`MIC_SRC_SH0] = 1'b1;
         grantVec = `MIC_VEC_SH0;
      end
      else if (pending[`MIC_SRC_SH1])
      begin
         grant[`MIC_SRC_SH1] = 1'b1;
         grantVec = `MIC_VEC_SH1;
      end
   end

   // RULE3 RULE8 RULE12 take only with global enable and stack room
   assign canTake = (stateReg == ST_IDLE) & ctrl0Reg[`MIC_B_GIE] & ~stackFull
                  & coreReady & (|pending);

   always @*
   begin
      case (stateReg)
         ST_IDLE: stateNext = canTake ? ST_PUSH : ST_IDLE;
         ST_PUSH: stateNext = ST_LOAD;
         ST_LOAD: stateNext = ST_IDLE;
         default: stateNext = ST_IDLE;
      endcase
   end

   // RULE6 RULE13 RULE21 auto-clear on take: global, and the taken flag only
   assign clrC0 = canTake ? (({7'b0, 1'b1} << `MIC_B_GIE)
                | ({7'b0, grant[`MIC_SRC_EXT]} << `MIC_B_EXTF)
                | ({7'b0, grant[`MIC_SRC_SH0]} << `MIC_B_SH0F)
                | ({7'b0, grant[`MIC_SRC_SH1]} << `MIC_B_SH1F)) : 8'h00;
   assign clrC1 = canTake ? (({7'b0, grant[`MIC_SRC_SER]} << `MIC_B_SERF)
                | ({7'b0, grant[`MIC_SRC_TB]} << `MIC_B_TBF)
                | ({7'b0, grant[`MIC_SRC_EE]} << `MIC_B_EEF)) : 8'h00;

   // AXI4-Lite: address and data may arrive in either order
   assign s_axi_awready = ~awHeldReg & ~s_axi_bvalid;
   assign s_axi_wready  = ~wHeldReg & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign doWrite = awHeldReg & wHeldReg & ~s_axi_bvalid & wStrbReg[0];
   assign wrByte  = wDataReg[7:0];
   assign doRead  = s_axi_arvalid & ~s_axi_rvalid;
   assign wrHit   = isAddr(awAddrReg, `MIC_OFS_EDGE) | isAddr(awAddrReg, `MIC_OFS_CTRL0)
                  | isAddr(awAddrReg, `MIC_OFS_CTRL1) | isAddr(awAddrReg, `MIC_OFS_TOUCH)
                  | isAddr(awAddrReg, `MIC_OFS_TIMER) | isAddr(awAddrReg, `MIC_OFS_CORE);

   // RULE16 RULE17 RULE18 RULE19 RULE20 read map, unused bits zero
   always @*
   begin
      rdHit = 1'b1;
      rdByte = 8'h00;
      if (isAddr(s_axi_araddr, `MIC_OFS_EDGE))
         rdByte = {6'b0, edgeSelReg};
      else if (isAddr(s_axi_araddr, `MIC_OFS_CTRL0))
         rdByte = ctrl0Reg;
      else if (isAddr(s_axi_araddr, `MIC_OFS_CTRL1))
         rdByte = ctrl1Reg;
      else if (isAddr(s_axi_araddr, `MIC_OFS_TOUCH))
         rdByte = touchReg;
      else if (isAddr(s_axi_araddr, `MIC_OFS_TIMER))
         rdByte = timerReg;
      else if (isAddr(s_axi_araddr, `MIC_OFS_CORE))
         rdByte = {5'b0, stateReg};
      else
         rdHit = 1'b0;
   end

   // RULE20 everything clears at reset except stateReg, which loads ST_IDLE
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         edgeSelReg   <= 2'h0;
         ctrl0Reg     <= `MIC_REG_RST;
         ctrl1Reg     <= `MIC_REG_RST;
         touchReg     <= `MIC_REG_RST;
         timerReg     <= `MIC_REG_RST;
         stateReg     <= ST_IDLE;
         takenSrcReg  <= {`MIC_NSRC{1'b0}};
         vectorReg    <= {`MIC_PC_W{1'b0}};
         savedPcReg   <= {`MIC_PC_W{1'b0}};
         pinPrevReg   <= 1'b0;
         awAddrReg    <= 12'h000;
         awHeldReg    <= 1'b0;
         wDataReg     <= 32'h0000_0000;
         wStrbReg     <= 4'h0;
         wHeldReg     <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `MIC_RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= `MIC_RESP_OKAY;
         s_axi_rdata  <= 32'h0000_0000;
         irqTake      <= 1'b0;
         stackPush    <= 1'b0;
         pushPc       <= {`MIC_PC_W{1'b0}};
         pcLoad       <= 1'b0;
         pcLoadValue  <= {`MIC_PC_W{1'b0}};
         stackPop     <= 1'b0;
         wakeUp       <= 1'b0;
      end
      else
      begin
         pinPrevReg <= pinLevel;
         // Bus channel capture
         if (s_axi_awvalid & s_axi_awready)
         begin
            awAddrReg <= s_axi_awaddr;
            awHeldReg <= 1'b1;
         end
         if (s_axi_wvalid & s_axi_wready)
         begin
            wDataReg <= s_axi_wdata;
            wStrbReg <= s_axi_wstrb;
            wHeldReg <= 1'b1;
         end
         if (awHeldReg & wHeldReg & ~s_axi_bvalid)
         begin
            awHeldReg    <= 1'b0;
            wHeldReg     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrHit ? `MIC_RESP_OKAY : `MIC_RESP_SLVERR;
         end
         else if (s_axi_bvalid & s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (doRead)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rdByte};
            s_axi_rresp  <= rdHit ? `MIC_RESP_OKAY : `MIC_RESP_SLVERR;
         end
         else if (s_axi_rvalid & s_axi_rready)
            s_axi_rvalid <= 1'b0;
         // Register state; hardware sets beat a same-cycle software write
         if (doWrite & isAddr(awAddrReg, `MIC_OFS_EDGE))
            edgeSelReg <= wrByte[1:0];
         ctrl0Reg <= upd(ctrl0Reg, doWrite & isAddr(awAddrReg, `MIC_OFS_CTRL0), wrByte,
                         `MIC_MASK_CTRL0, clrC0, setC0);
         ctrl1Reg <= upd(ctrl1Reg, doWrite & isAddr(awAddrReg, `MIC_OFS_CTRL1), wrByte,
                         `MIC_MASK_CTRL1, clrC1, setC1);
         // RULE21 source flags stay for software to clear
         touchReg <= upd(touchReg, doWrite & isAddr(awAddrReg, `MIC_OFS_TOUCH), wrByte,
                         `MIC_MASK_SUB, 8'h00, setTouch);
         timerReg <= upd(timerReg, doWrite & isAddr(awAddrReg, `MIC_OFS_TIMER), wrByte,
                         `MIC_MASK_SUB, 8'h00, setTimer);
         // RULE9 RULE10 only a newly set flag wakes; a preset flag stays quiet
         wakeUp <= lowPower & (|(setC0 & ~ctrl0Reg) | |(setC1 & ~ctrl1Reg)
                             | |(setTouch & ~touchReg) | |(setTimer & ~timerReg));
         // RULE4 push PC, then load vector
         stateReg  <= stateNext;
         irqTake   <= canTake;
         stackPush <= 1'b0;
         pcLoad    <= 1'b0;
         stackPop  <= 1'b0;
         if (canTake)
         begin
            takenSrcReg <= grant;
            vectorReg   <= grantVec;
            savedPcReg  <= corePc;
         end
         if (stateReg == ST_PUSH)
         begin
            stackPush <= 1'b1;
            pushPc    <= savedPcReg;
         end
         if (stateReg == ST_LOAD)
         begin
            pcLoad      <= 1'b1;
            pcLoadValue <= vectorReg;
         end
         // RULE5 return pops saved PC and reloads it
         else if (returnFromIrq & (stateReg == ST_IDLE))
         begin
            stackPop    <= 1'b1;
            pcLoad      <= 1'b1;
            pcLoadValue <= stackTopPc;
         end
      end
   end

endmodule

// >>> logic/mic_irq_consts.vh
// Register offsets, bit positions, vectors and widths of the interrupt controller
`ifndef MIC_IRQ_CONSTS_VH
`define MIC_IRQ_CONSTS_VH
`define MIC_OFS_EDGE      12'h000
`define MIC_OFS_CTRL0     12'h004
`define MIC_OFS_CTRL1     12'h008
`define MIC_OFS_TOUCH     12'h00C
`define MIC_OFS_TIMER     12'h010
`define MIC_OFS_CORE      12'h014
`define MIC_ADDR_W        12
`define MIC_PC_W          13
`define MIC_REG_RST       8'h00
`define MIC_EDGE_OFF      2'h0
`define MIC_EDGE_RISE     2'h1
`define MIC_EDGE_FALL     2'h2
`define MIC_EDGE_BOTH     2'h3
`define MIC_B_GIE         0
`define MIC_B_EXTE        1
`define MIC_B_SH0E        2
`define MIC_B_SH1E        3
`define MIC_B_EXTF        4
`define MIC_B_SH0F        5
`define MIC_B_SH1F        6
`define MIC_B_SERE        0
`define MIC_B_TBE         1
`define MIC_B_EEE         2
`define MIC_B_SERF        4
`define MIC_B_TBF         5
`define MIC_B_EEF         6
`define MIC_B_LO_E        0
`define MIC_B_HI_E        1
`define MIC_B_LO_F        4
`define MIC_B_HI_F        5
`define MIC_MASK_EDGE     8'h03
`define MIC_MASK_CTRL0    8'h7F
`define MIC_MASK_CTRL1    8'h77
`define MIC_MASK_SUB      8'h33
`define MIC_VEC_EXT       13'h0004
`define MIC_VEC_SER       13'h0008
`define MIC_VEC_TB        13'h000C
`define MIC_VEC_EE        13'h0010
`define MIC_VEC_SH0       13'h0014
`define MIC_VEC_SH1       13'h0018
`define MIC_SRC_EXT       0
`define MIC_SRC_SER       1
`define MIC_SRC_TB        2
`define MIC_SRC_EE        3
`define MIC_SRC_SH0       4
`define MIC_SRC_SH1       5
`define MIC_NSRC          6
`define MIC_RESP_OKAY     2'h0
`define MIC_RESP_SLVERR   2'h2
`endif

// >>> logic/mic_pin_sync.v
// Three-stage input synchroniser with agreement-based change detection
module mic_pin_sync
(
   // Clock and reset
   input  wire clock,
   input  wire rst_n,
   // Asynchronous pin and filtered level
   input  wire pinIn,
   output reg  levelOut
);

   reg stage1Reg;
   reg stage2Reg;
   reg stage3Reg;

   // Level only follows when stages two and three agree
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stage1Reg <= 1'b0;
         stage2Reg <= 1'b0;
         stage3Reg <= 1'b0;
         levelOut  <= 1'b0;
      end
      else
      begin
         stage1Reg <= pinIn;
         stage2Reg <= stage1Reg;
         stage3Reg <= stage2Reg;
         if (stage2Reg == stage3Reg)
         begin
            levelOut <= stage3Reg;
         end
      end
   end

endmodule

// >>> testbench/mic_irq_monitor.sv
// Checker on the interrupt controller top ports
`include "mic_irq_consts.vh"
module mic_irq_monitor
(
   // Clock and reset
   input logic                 clock,
   input logic                 rst_n,
   // Core side, plus the serial interface event
   input logic                 coreReady,
   input logic [`MIC_PC_W-1:0] corePc,
   input logic                 stackFull,
   input logic                 returnFromIrq,
   input logic [`MIC_PC_W-1:0] stackTopPc,
   input logic                 lowPower,
   input logic                 serialIfEvent,
   // Controller outputs
   input logic                 irqTake,
   input logic                 stackPush,
   input logic [`MIC_PC_W-1:0] pushPc,
   input logic                 pcLoad,
   input logic [`MIC_PC_W-1:0] pcLoadValue,
   input logic                 stackPop,
   input logic                 wakeUp
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   take_push_a: assert property (irqTake |=> stackPush && pushPc == $past(corePc, 2))
      else $error("push missing or wrong pc");
   push_load_a: assert property (stackPush |=> pcLoad)
      else $error("vector load missing");
   vector_set_a: assert property (pcLoad && !stackPop |-> pcLoadValue inside {`MIC_VEC_EXT,
      `MIC_VEC_SER, `MIC_VEC_TB, `MIC_VEC_EE, `MIC_VEC_SH0, `MIC_VEC_SH1})
      else $error("unknown vector");
   pop_resume_a: assert property (stackPop |-> pcLoad && $past(returnFromIrq)
      && pcLoadValue == $past(stackTopPc)) else $error("return pc wrong");
   full_block_a: assert property (irqTake |-> !$past(stackFull) && $past(coreReady))
      else $error("take while stack full");
   no_nest_a: assert property (irqTake |=> !irqTake [*2])
      else $error("nested take");
   wake_event_a: assert property (lowPower && serialIfEvent |=> wakeUp)
      else $error("no wake");
   wake_cause_a: assert property (wakeUp |-> $past(lowPower))
      else $error("wake while awake");
   cover property (irqTake);
   cover property (stackPop);
   cover property (wakeUp);
endmodule
bind mic_irq_controller mic_irq_monitor mon_u (.clock(clock), .rst_n(rst_n),
   .coreReady(coreReady), .corePc(corePc), .stackFull(stackFull),
   .returnFromIrq(returnFromIrq), .stackTopPc(stackTopPc), .lowPower(lowPower),
   .serialIfEvent(serialIfEvent), .irqTake(irqTake), .stackPush(stackPush),
   .pushPc(pushPc), .pcLoad(pcLoad), .pcLoadValue(pcLoadValue), .stackPop(stackPop),
   .wakeUp(wakeUp));

// >>> testbench/mic_core_model.sv
// Core and stack model facing the controller
module mic_core_model
#(parameter int DEPTH = 4)
(
   // Clock and reset
   input  logic        clock,
   input  logic        rst_n,
   // Bench commands
   input  logic        retReq,
   input  logic        holdFull,
   // From controller
   input  logic        stackPush,
   input  logic [12:0] pushPc,
   input  logic        stackPop,
   // To controller
   output logic        coreReady,
   output logic [12:0] corePc,
   output logic        stackFull,
   output logic        returnFromIrq,
   output logic [12:0] stackTopPc
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [12:0] stack [DEPTH];
   int          depth;
   assign coreReady = 1'b1;
   assign stackFull = holdFull || depth == DEPTH;
   // Empty stack shows garbage, not a stale value
   assign stackTopPc = depth > 0 ? stack[depth-1] : ~corePc;
   always @(posedge clock or negedge rst_n)
      if (!rst_n)
      begin
         corePc <= 13'h0000;
         depth <= 0;
         returnFromIrq <= 1'b0;
      end
      else
      begin
         corePc <= corePc + 13'h0001;
         returnFromIrq <= retReq && depth > 0;
         if (stackPush)
         begin
            stack[depth] <= pushPc;
            depth <= depth + 1;
         end
         else if (stackPop)
            depth <= depth - 1;
      end
endmodule

// >>> testbench/mic_irq_controller_bench.sv
// Self-checking bench for the interrupt controller
`include "mic_irq_consts.vh"
module mic_irq_controller_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock, rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, extPin, lowPower, retReq, holdFull;
   logic        coreReady, stackFull, returnFromIrq, irqTake, stackPush, pcLoad, stackPop, wakeUp;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, v;
   logic [1:0]  bresp, rresp, r;
   logic [6:0]  ev;
   logic [12:0] corePc, stackTopPc, pushPc, pcLoadValue, lastPush, vec;
   int          bad_count, total_checks, takes, wakes;
   logic [11:0] ofs [5] = '{`MIC_OFS_EDGE, `MIC_OFS_CTRL0, `MIC_OFS_CTRL1, `MIC_OFS_TOUCH,
                            `MIC_OFS_TIMER};
   logic [31:0] wr [5] = '{32'h0000_00FF, 32'h0000_007E, 32'h0000_00FF, 32'h0000_00FF,
                           32'h0000_00FF};
   logic [31:0] rb [5] = '{32'h0000_0003, 32'h0000_007E, 32'h0000_0077, 32'h0000_0033,
                           32'h0000_0033};
   logic [12:0] pri [5] = '{`MIC_VEC_SER, `MIC_VEC_TB, `MIC_VEC_EE, `MIC_VEC_SH0, `MIC_VEC_SH1};

   mic_irq_controller dut_u (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .extPin(extPin),
      .serialIfEvent(ev[0]), .timebaseEvent(ev[1]), .eepromDoneEvent(ev[2]),
      .touchSlotOvfEvent(ev[3]), .touchThresholdEvent(ev[4]), .timerCmpPEvent(ev[5]),
      .timerCmpAEvent(ev[6]), .coreReady(coreReady), .corePc(corePc), .stackFull(stackFull),
      .returnFromIrq(returnFromIrq), .stackTopPc(stackTopPc), .lowPower(lowPower),
      .irqTake(irqTake), .stackPush(stackPush), .pushPc(pushPc), .pcLoad(pcLoad),
      .pcLoadValue(pcLoadValue), .stackPop(stackPop), .wakeUp(wakeUp));
   mic_core_model core_u (.clock(clock), .rst_n(rst_n), .retReq(retReq), .holdFull(holdFull),
      .stackPush(stackPush), .pushPc(pushPc), .stackPop(stackPop), .coreReady(coreReady),
      .corePc(corePc), .stackFull(stackFull), .returnFromIrq(returnFromIrq),
      .stackTopPc(stackTopPc));

   initial
   begin
      clock = 0;
      forever #25 clock = ~clock;
   end
   always @(posedge clock)
   begin
      if (irqTake === 1'b1) takes++;
      if (wakeUp === 1'b1) wakes++;
      if (stackPush === 1'b1) lastPush <= pushPc;
   end

   task print_verdict;
      $display("checks %0d errors %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Bounded edge wait; a stuck handshake ends the run
   task tick(inout int n);
      @(posedge clock);
      n++;
      if (n > 200)
      begin
         check(n, 0);
         print_verdict;
      end
   endtask
   task axiWrite(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rsp);
      int   n;
      logic aw, w;
      n = 0;
      aw = 0;
      w = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      while (!(aw && w))
      begin
         tick(n);
         if (awvalid && awready === 1'b1) begin aw = 1; awvalid <= 0; end
         if (wvalid && wready === 1'b1) begin w = 1; wvalid <= 0; end
      end
      do tick(n); while (bvalid !== 1'b1);
      rsp = bresp;
   endtask
   task axiRead(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rsp);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1;
      do tick(n); while (arready !== 1'b1);
      arvalid <= 0;
      do tick(n); while (rvalid !== 1'b1);
      d = rdata;
      rsp = rresp;
   endtask
   task expRead(input logic [11:0] a, input logic [31:0] exp);
      axiRead(a, v, r);
      check(v, exp);
   endtask
   task pulse(input logic [6:0] m);
      ev <= m;
      @(posedge clock);
      ev <= 0;
      @(posedge clock);
   endtask
   task waitLoad;
      int n;
      n = 0;
      do tick(n); while (pcLoad !== 1'b1);
      vec = pcLoadValue;
   endtask
   task doReturn;
      retReq <= 1;
      @(posedge clock);
      retReq <= 0;
      waitLoad;
      check(vec, lastPush);
   endtask

   initial
   begin
      {rst_n, awvalid, wvalid, arvalid, extPin, lowPower, retReq, holdFull} = 0;
      {awaddr, araddr, wdata, ev} = 0;
      bready = 1;
      rready = 1;
      repeat (20) @(posedge clock);
      rst_n <= 1;
      foreach (ofs[i])
      begin
         expRead(ofs[i], 32'h0000_0000);
         axiWrite(ofs[i], wr[i], r);
         check(r, `MIC_RESP_OKAY);
         expRead(ofs[i], rb[i]);
         axiWrite(ofs[i], 32'h0000_0000, r);
      end
      axiRead(12'h020, v, r);
      check(r, `MIC_RESP_SLVERR);
      axiWrite(12'h020, 32'h0000_00FF, r);
      check(r, `MIC_RESP_SLVERR);
      expRead(`MIC_OFS_CORE, 32'h0000_0001);
      // Flag latches with global enable off, then is taken
      axiWrite(`MIC_OFS_CTRL1, 32'h0000_0001, r);
      pulse(7'h01);
      expRead(`MIC_OFS_CTRL1, 32'h0000_0011);
      check(takes, 0);
      axiWrite(`MIC_OFS_CTRL0, 32'h0000_0001, r);
      waitLoad;
      check(vec, `MIC_VEC_SER);
      expRead(`MIC_OFS_CTRL0, 32'h0000_0000);
      expRead(`MIC_OFS_CTRL1, 32'h0000_0001);
      doReturn;
      // Full stack holds the request off
      holdFull <= 1;
      axiWrite(`MIC_OFS_CTRL1, 32'h0000_0002, r);
      pulse(7'h02);
      axiWrite(`MIC_OFS_CTRL0, 32'h0000_0001, r);
      repeat (10) @(posedge clock);
      check(takes, 1);
      holdFull <= 0;
      waitLoad;
      check(vec, `MIC_VEC_TB);
      doReturn;
      // All sources except the pin at once, served one at a time
      axiWrite(`MIC_OFS_TOUCH, 32'h0000_0003, r);
      axiWrite(`MIC_OFS_TIMER, 32'h0000_0003, r);
      axiWrite(`MIC_OFS_CTRL1, 32'h0000_0007, r);
      axiWrite(`MIC_OFS_CTRL0, 32'h0000_000C, r);
      pulse(7'h7F);
      foreach (pri[i])
      begin
         axiRead(`MIC_OFS_CTRL0, v, r);
         axiWrite(`MIC_OFS_CTRL0, v | 32'h0000_0001, r);
         waitLoad;
         check(vec, pri[i]);
         doReturn;
      end
      expRead(`MIC_OFS_TOUCH, 32'h0000_0033);
      expRead(`MIC_OFS_CTRL0, 32'h0000_000C);
      axiWrite(`MIC_OFS_CTRL0, 32'h0000_0000, r);
      // Pin edge modes
      for (int m = 0; m < 4; m++)
      begin
         axiWrite(`MIC_OFS_EDGE, 32'(m), r);
         extPin <= 1;
         repeat (8) @(posedge clock);
         expRead(`MIC_OFS_CTRL0, 32'(m & 1) << 4);
         axiWrite(`MIC_OFS_CTRL0, 32'h0000_0000, r);
         extPin <= 0;
         repeat (8) @(posedge clock);
         expRead(`MIC_OFS_CTRL0, 32'(m >> 1) << 4);
         axiWrite(`MIC_OFS_CTRL0, 32'h0000_0000, r);
      end
      axiWrite(`MIC_OFS_EDGE, `MIC_EDGE_RISE, r);
      axiWrite(`MIC_OFS_CTRL0, 32'h0000_0003, r);
      extPin <= 1;
      waitLoad;
      check(vec, `MIC_VEC_EXT);
      expRead(`MIC_OFS_CTRL0, 32'h0000_0002);
      doReturn;
      // Wake from low power
      lowPower <= 1;
      pulse(7'h01);
      @(posedge clock);
      check(wakes, 1);
      // Flag preset before the event: no second wake
      axiWrite(`MIC_OFS_CTRL1, 32'h0000_0020, r);
      pulse(7'h02);
      @(posedge clock);
      check(wakes, 1);
      print_verdict;
   end
endmodule
